// File: src/dcpet_top.sv
// three-channel timer with pwm, event count and input capture, apb slave
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "dcpet_defs.svh"

module dcpet_top
#(
   parameter int N_TIMERS = 3,
   parameter int CNT_W    = 16
)
(
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic                CE,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic [N_TIMERS-1:0] PIN_A_I,
   output logic      [N_TIMERS-1:0] PIN_A_O,
   output logic      [N_TIMERS-1:0] PIN_A_OE,
   input  wire logic [N_TIMERS-1:0] PIN_B_I,
   input  wire logic                CMP_OUT,
   output logic      [N_TIMERS-1:0] IRQ_A,
   output logic      [N_TIMERS-1:0] IRQ_B
);

   //---------------------------------------------------------------------------
   // elaboration checks
   //---------------------------------------------------------------------------
   initial
   begin
      if (N_TIMERS < 2 || N_TIMERS > 3)
         $error("N_TIMERS must be 2 or 3");
      if (CNT_W < 2 || CNT_W > 32)
         $error("CNT_W must be 2 to 32");
   end

   //---------------------------------------------------------------------------
   // decode functions
   //---------------------------------------------------------------------------
   // mode from bits 7 and 6 (C3, C2) of the control byte
   function automatic dcpet_pkg::dcpet_mode_type mode_of(input logic [`DCPET_CTRL_W-1:0] c);
      dcpet_pkg::dcpet_mode_type m;
      m = dcpet_pkg::DCPET_EVENT;
      if (c[`DCPET_C2])
         m = dcpet_pkg::DCPET_CAPTURE;
      else if (c[`DCPET_C3])
         m = dcpet_pkg::DCPET_PWM;
      return m;
   endfunction : mode_of

   // true for a mapped byte address
   function automatic logic addr_ok(input logic [7:0] a);
      logic ok;
      ok = (a == `DCPET_ADDR_CFG);
      if (a[1:0] == 2'h0 && 32'(a[7:`DCPET_CH_STRIDE_LSB]) < N_TIMERS)
         ok = 1'b1;
      return ok;
   endfunction : addr_ok

   //---------------------------------------------------------------------------
   // pin edge detection
   //---------------------------------------------------------------------------
   logic [N_TIMERS-1:0] a_rise;
   logic [N_TIMERS-1:0] a_fall;
   logic [N_TIMERS-1:0] b_rise;
   logic [N_TIMERS-1:0] b_fall;
   logic                cmp_rise;
   logic                cmp_fall;

   // one synchroniser per pin
   for (genvar g = 0; g < N_TIMERS; g++)
   begin : g_pin
      dcpet_edge u_edge_a
      (
         .CLK   (CLK),
         .RST_N (RST_N),
         .ce    (CE),
         .pin   (PIN_A_I[g]),
         .rise  (a_rise[g]),
         .fall  (a_fall[g])
      );
      dcpet_edge u_edge_b
      (
         .CLK   (CLK),
         .RST_N (RST_N),
         .ce    (CE),
         .pin   (PIN_B_I[g]),
         .rise  (b_rise[g]),
         .fall  (b_fall[g])
      );
   end

   // comparator output, asynchronous to this clock
   dcpet_edge u_edge_cmp
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .ce    (CE),
      .pin   (CMP_OUT),
      .rise  (cmp_rise),
      .fall  (cmp_fall)
   );

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   logic [`DCPET_CTRL_W-1:0] ctrl_r   [N_TIMERS];
   logic [`DCPET_CTRL_W-1:0] ctrl_nxt [N_TIMERS];
   logic [CNT_W-1:0]         cnt_r    [N_TIMERS];
   logic [CNT_W-1:0]         cnt_nxt  [N_TIMERS];
   logic [CNT_W-1:0]         ra_r     [N_TIMERS];
   logic [CNT_W-1:0]         ra_nxt   [N_TIMERS];
   logic [CNT_W-1:0]         rb_r     [N_TIMERS];
   logic [CNT_W-1:0]         rb_nxt   [N_TIMERS];
   logic [N_TIMERS-1:0]      alt_r;
   logic [N_TIMERS-1:0]      alt_nxt;
   logic [N_TIMERS-1:0]      pin_o_r;
   logic [N_TIMERS-1:0]      pin_o_nxt;
   logic [N_TIMERS-1:0]      pin_oe_r;
   logic [N_TIMERS-1:0]      pin_oe_nxt;
   logic [N_TIMERS-1:0]      irq_a_r;
   logic [N_TIMERS-1:0]      irq_a_nxt;
   logic [N_TIMERS-1:0]      irq_b_r;
   logic [N_TIMERS-1:0]      irq_b_nxt;
   logic                     cmp_sel_r;
   logic                     cmp_sel_nxt;
   logic [31:0]              prdata_r;
   logic [31:0]              prdata_nxt;
   logic                     pready_r;
   logic                     pready_nxt;
   logic                     pslverr_r;
   logic                     pslverr_nxt;

   //---------------------------------------------------------------------------
   // apb slave
   //---------------------------------------------------------------------------
   logic       setup;
   logic       wr_en;
   logic [1:0] reg_sel;
   int         ch_sel;

   assign setup   = PSEL & ~PENABLE;
   assign wr_en   = PSEL & PENABLE & PWRITE & pready_r & ~pslverr_r;
   assign reg_sel = PADDR[`DCPET_REG_LSB +: 2];
   assign ch_sel  = 32'(PADDR[7:`DCPET_CH_STRIDE_LSB]);

   // one wait-free access phase; read data taken at setup
   always_comb
   begin
      pready_nxt  = pready_r;
      pslverr_nxt = pslverr_r;
      prdata_nxt  = prdata_r;
      cmp_sel_nxt = cmp_sel_r;
      if (CE)
      begin
         pready_nxt  = setup;
         pslverr_nxt = setup & ~addr_ok(PADDR);
         if (setup)
         begin
            prdata_nxt = 32'h0000_0000;
            if (PADDR == `DCPET_ADDR_CFG)
               prdata_nxt[`DCPET_CFG_CMP_SEL] = cmp_sel_r;
            else if (addr_ok(PADDR) && !PWRITE)
            begin
               case (reg_sel)
                  `DCPET_OFF_CTRL     : prdata_nxt[`DCPET_CTRL_W-1:0] = ctrl_r[ch_sel];
                  `DCPET_OFF_COUNT    : prdata_nxt[CNT_W-1:0] = cnt_r[ch_sel];
                  `DCPET_OFF_RELOAD_A : prdata_nxt[CNT_W-1:0] = ra_r[ch_sel];
                  `DCPET_OFF_RELOAD_B : prdata_nxt[CNT_W-1:0] = rb_r[ch_sel];
                  default             : prdata_nxt = 32'h0000_0000;
               endcase
            end
         end
         if (wr_en && PADDR == `DCPET_ADDR_CFG)
            cmp_sel_nxt = PWDATA[`DCPET_CFG_CMP_SEL];
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         cmp_sel_r <= `DCPET_RST_CFG;
      end
      else
      begin
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
         cmp_sel_r <= cmp_sel_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // timer channels, identical logic per index
   //---------------------------------------------------------------------------
   always_comb
   begin
      dcpet_pkg::dcpet_mode_type m;
      logic [`DCPET_CTRL_W-1:0]  c;
      logic                      tick;
      logic                      uf;
      logic                      b_r;
      logic                      b_f;
      logic                      ev_a;
      logic                      ev_b;
      logic                      set_a;
      logic                      set_b;
      logic                      set_u;
      logic                      wr_ch;
      m     = dcpet_pkg::DCPET_EVENT;
      c     = '0;
      tick  = 1'b0;
      uf    = 1'b0;
      b_r   = 1'b0;
      b_f   = 1'b0;
      ev_a  = 1'b0;
      ev_b  = 1'b0;
      set_a = 1'b0;
      set_b = 1'b0;
      set_u = 1'b0;
      wr_ch = 1'b0;
      for (int i = 0; i < N_TIMERS; i++)
      begin
         ctrl_nxt[i]   = ctrl_r[i];
         cnt_nxt[i]    = cnt_r[i];
         ra_nxt[i]     = ra_r[i];
         rb_nxt[i]     = rb_r[i];
         alt_nxt[i]    = alt_r[i];
         pin_o_nxt[i]  = pin_o_r[i];
         pin_oe_nxt[i] = pin_oe_r[i];
         irq_a_nxt[i]  = irq_a_r[i];
         irq_b_nxt[i]  = irq_b_r[i];
         if (CE)
         begin
            c     = ctrl_r[i];
            m     = mode_of(c);
            wr_ch = wr_en && ch_sel == i && PADDR != `DCPET_ADDR_CFG;
            // pin B path, comparator on the selected channel
            b_r = b_rise[i];
            b_f = b_fall[i];
            if (i == `DCPET_CMP_CH && cmp_sel_r)
            begin
               b_r = cmp_rise;
               b_f = cmp_fall;
            end
            set_a = 1'b0;
            set_b = 1'b0;
            set_u = 1'b0;
            ev_a  = 1'b0;
            ev_b  = 1'b0;
            // software writes first, hardware updates below override
            if (wr_ch && reg_sel == `DCPET_OFF_CTRL)
               ctrl_nxt[i] = PWDATA[`DCPET_CTRL_W-1:0];
            if (wr_ch && reg_sel == `DCPET_OFF_RELOAD_A)
               ra_nxt[i] = PWDATA[CNT_W-1:0];
            if (wr_ch && reg_sel == `DCPET_OFF_RELOAD_B)
               rb_nxt[i] = PWDATA[CNT_W-1:0];
            // count enable per mode
            case (m)
               dcpet_pkg::DCPET_PWM     : tick = c[`DCPET_C0];
               dcpet_pkg::DCPET_EVENT   : tick = c[`DCPET_C0] & (c[`DCPET_C1] ? a_fall[i] : a_rise[i]);
               dcpet_pkg::DCPET_CAPTURE : tick = 1'b1;
               default                  : tick = 1'b0;
            endcase
            uf = tick && cnt_r[i] == '0;
            if (tick)
               cnt_nxt[i] = cnt_r[i] - 1'b1;
            case (m)
               dcpet_pkg::DCPET_PWM :
               begin
                  if (uf)
                  begin
                     cnt_nxt[i] = alt_r[i] ? rb_r[i] : ra_r[i];
                     set_a      = ~alt_r[i];
                     set_b      = alt_r[i];
                     alt_nxt[i] = ~alt_r[i];
                     if (c[`DCPET_C1])
                        pin_o_nxt[i] = ~pin_o_r[i];
                  end
                  if (!c[`DCPET_C0])
                     alt_nxt[i] = 1'b0;
               end
               dcpet_pkg::DCPET_EVENT :
               begin
                  if (uf)
                  begin
                     cnt_nxt[i] = ra_r[i];
                     set_a      = 1'b1;
                  end
                  set_b      = b_r;
                  alt_nxt[i] = 1'b0;
               end
               dcpet_pkg::DCPET_CAPTURE :
               begin
                  ev_a  = c[`DCPET_C1] ? a_fall[i] : a_rise[i];
                  ev_b  = c[`DCPET_C3] ? b_f : b_r;
                  set_a = ev_a;
                  set_b = ev_b;
                  set_u = uf;
                  if (ev_a)
                     ra_nxt[i] = cnt_r[i];
                  if (ev_b)
                     rb_nxt[i] = cnt_r[i];
                  alt_nxt[i] = 1'b0;
               end
               default : alt_nxt[i] = 1'b0;
            endcase
            // counter write beats the hardware decrement
            if (wr_ch && reg_sel == `DCPET_OFF_COUNT)
               cnt_nxt[i] = PWDATA[CNT_W-1:0];
            // sticky flags, hardware set wins over a clear
            if (set_a)
               ctrl_nxt[i][`DCPET_PNDA] = 1'b1;
            if (set_b)
               ctrl_nxt[i][`DCPET_PNDB] = 1'b1;
            if (set_u)
               ctrl_nxt[i][`DCPET_C0] = 1'b1;
            // pin A driven only in pwm toggle mode
            pin_oe_nxt[i] = (mode_of(ctrl_nxt[i]) == dcpet_pkg::DCPET_PWM) && ctrl_nxt[i][`DCPET_C1];
            // interrupt requests from the flags as they will stand
            irq_a_nxt[i] = ctrl_nxt[i][`DCPET_ENA] & (ctrl_nxt[i][`DCPET_PNDA] |
                           (ctrl_nxt[i][`DCPET_C0] &
                           (mode_of(ctrl_nxt[i]) == dcpet_pkg::DCPET_CAPTURE)));
            irq_b_nxt[i] = ctrl_nxt[i][`DCPET_ENB] & ctrl_nxt[i][`DCPET_PNDB];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         for (int i = 0; i < N_TIMERS; i++)
         begin
            ctrl_r[i] <= `DCPET_RST_CTRL;
            cnt_r[i]  <= '0;
            ra_r[i]   <= '0;
            rb_r[i]   <= '0;
         end
         alt_r    <= '0;
         pin_o_r  <= '0;
         pin_oe_r <= '0;
         irq_a_r  <= '0;
         irq_b_r  <= '0;
      end
      else
      begin
         for (int i = 0; i < N_TIMERS; i++)
         begin
            ctrl_r[i] <= ctrl_nxt[i];
            cnt_r[i]  <= cnt_nxt[i];
            ra_r[i]   <= ra_nxt[i];
            rb_r[i]   <= rb_nxt[i];
         end
         alt_r    <= alt_nxt;
         pin_o_r  <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
         irq_a_r  <= irq_a_nxt;
         irq_b_r  <= irq_b_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // outputs, all straight from flops
   //---------------------------------------------------------------------------
   assign PRDATA   = prdata_r;
   assign PREADY   = pready_r;
   assign PSLVERR  = pslverr_r;
   assign PIN_A_O  = pin_o_r;
   assign PIN_A_OE = pin_oe_r;
   assign IRQ_A    = irq_a_r;
   assign IRQ_B    = irq_b_r;

endmodule : dcpet_top

// File: inc/dcpet_defs.svh
// constants for the dual capture / pwm / event timer block
//------------------------------------------------------------------------------
// How it works
//------------------------------------------------------------------------------
// How it works
// - capture mode: pin A edge copies counter into A, pin B edge into B
// - capture edge polarity chosen separately for pin A and pin B by mode bits
// - pin A trigger sets pending A, pin B trigger sets pending B; both sticky
// - interrupt A only while enable A set; enable B gates source B alike
// - second timer's B input may come from the internal comparator output
// - capture mode: counter underflow sets the run/underflow bit as pending flag
// - capture mode interrupt A is (pending A or underflow) gated by enable A
// - pwm and event modes: run/underflow bit 1 runs, 0 stops the counter
// - enable flag 1 enables its interrupt source, 0 disables it
// - mode bits 000/001 event count, 101/100 pwm, bit2 set capture
// - capture: bit1 picks pin A edge, bit3 picks pin B edge, 0 rise 1 fall
// - all timer instances share one control structure and behaviour
// - pwm counts down; first underflow reloads A, then alternately from B
// - pwm reload from A sets pending A, reload from B sets pending B
// - event mode: pin B rising edge sets pending B, underflow sets pending A
`ifndef DCPET_DEFS_SVH
`define DCPET_DEFS_SVH

//------------------------------------------------------------------------------
// register map
//------------------------------------------------------------------------------
`define DCPET_CH_STRIDE_LSB 4
`define DCPET_REG_LSB       2
`define DCPET_OFF_CTRL      2'h0
`define DCPET_OFF_COUNT     2'h1
`define DCPET_OFF_RELOAD_A  2'h2
`define DCPET_OFF_RELOAD_B  2'h3
`define DCPET_ADDR_CFG      8'h30
`define DCPET_CFG_CMP_SEL   0

//------------------------------------------------------------------------------
// control register fields
//------------------------------------------------------------------------------
`define DCPET_C3   7
`define DCPET_C2   6
`define DCPET_C1   5
`define DCPET_C0   4
`define DCPET_PNDA 3
`define DCPET_ENA  2
`define DCPET_PNDB 1
`define DCPET_ENB  0
`define DCPET_CTRL_W 8

//------------------------------------------------------------------------------
// reset values and fixed figures
//------------------------------------------------------------------------------
`define DCPET_RST_CTRL 8'h00
`define DCPET_RST_CFG  1'h0
`define DCPET_CMP_CH   1

`endif

// File: inc/dcpet_pkg.sv
// types shared by the timer block
package dcpet_pkg;

   // decoded operating mode, one-hot
   typedef enum logic [2:0]
   {
      DCPET_EVENT   = 3'b001,
      DCPET_PWM     = 3'b010,
      DCPET_CAPTURE = 3'b100
   } dcpet_mode_type;

endpackage : dcpet_pkg

// File: src/dcpet_edge.sv
// pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps

module dcpet_edge
(
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic ce,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);

   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic meta_nxt;
   logic sync_nxt;
   logic prev_nxt;

   // two-stage sync, third stage holds last sample
   always_comb
   begin
      meta_nxt = meta_r;
      sync_nxt = sync_r;
      prev_nxt = prev_r;
      if (ce)
      begin
         meta_nxt = pin;
         sync_nxt = meta_r;
         prev_nxt = sync_r;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   // compare successive samples
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

endmodule : dcpet_edge

// File: bench/dcpet_pins_model.sv
// far-side model: pin a/b levels and comparator output
`timescale 1ns/1ps

module dcpet_pins_model
(
   input  wire logic       CLK,
   input  wire logic [2:0] PIN_A_O,
   input  wire logic [2:0] PIN_A_OE,
   output logic      [2:0] PIN_A_I,
   output logic      [2:0] PIN_B_I,
   output logic            CMP_OUT
);
   logic [2:0] a_lvl = 3'h0;

   // wire level of pin a: the timer wins while it drives
   assign PIN_A_I = (PIN_A_OE & PIN_A_O) | (~PIN_A_OE & a_lvl);

   initial
   begin
      PIN_B_I = 3'h0;
      CMP_OUT = 1'b0;
   end

   // change one line just after a rising edge; 0 pin a, 1 pin b, 2 comparator
   task automatic set_pin(input int which, input int ch, input logic v);
      @(posedge CLK);
      case (which)
         0: a_lvl[ch] <= v;
         1: PIN_B_I[ch] <= v;
         default: CMP_OUT <= v;
      endcase
   endtask : set_pin

   // active level for 3 cycles, then back to idle
   task automatic pulse(input int which, input int ch, input logic act);
      set_pin(which, ch, act);
      repeat (2) @(posedge CLK);
      set_pin(which, ch, ~act);
   endtask : pulse
endmodule : dcpet_pins_model

// File: bench/dcpet_top_sva.sv
// port assertions for the timer block
`timescale 1ns/1ps

module dcpet_top_sva
#(
   parameter int N_TIMERS = 3,
   parameter int CNT_W    = 16
)
(
   input wire logic                CLK,
   input wire logic                RST_N,
   input wire logic                CE,
   input wire logic                PSEL,
   input wire logic                PENABLE,
   input wire logic                PWRITE,
   input wire logic [7:0]          PADDR,
   input wire logic [31:0]         PWDATA,
   input wire logic [31:0]         PRDATA,
   input wire logic                PREADY,
   input wire logic                PSLVERR,
   input wire logic [N_TIMERS-1:0] PIN_A_I,
   input wire logic [N_TIMERS-1:0] PIN_A_O,
   input wire logic [N_TIMERS-1:0] PIN_A_OE,
   input wire logic [N_TIMERS-1:0] PIN_B_I,
   input wire logic                CMP_OUT,
   input wire logic [N_TIMERS-1:0] IRQ_A,
   input wire logic [N_TIMERS-1:0] IRQ_B
);
   logic wr_acc;

   // ----------------------------------------
   // completed register write
   // ----------------------------------------
   assign wr_acc = PSEL && PENABLE && PWRITE && PREADY && CE;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   AST_IRQ_A_STICKY: assert property (|($past(IRQ_A) & ~IRQ_A) |-> $past(wr_acc))
      else $error("irq a fell without a register write");
   AST_IRQ_B_STICKY: assert property (|($past(IRQ_B) & ~IRQ_B) |-> $past(wr_acc))
      else $error("irq b fell without a register write");
   AST_OE_BY_MODE: assert property ($changed(PIN_A_OE) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("pin a enable changed without a mode write");
   AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE && CE ##1 CE |-> PREADY)
      else $error("no ready in access cycle");
   AST_READY_ONE_CYCLE: assert property (PREADY && CE |=> !PREADY)
      else $error("ready held two cycles");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_ERR_UNMAPPED: assert property (PSEL && !PENABLE && CE && PADDR == 8'h34 ##1 CE |-> PSLVERR)
      else $error("unmapped address not refused");
   AST_NO_ERR_MAPPED: assert property (PSEL && !PENABLE && CE && PADDR < 8'h30 && PADDR[1:0] == 2'h0
                                       ##1 CE |-> PREADY && !PSLVERR)
      else $error("mapped address refused");

   COV_IRQ_A: cover property ($rose(IRQ_A[0]));
   COV_IRQ_B: cover property ($rose(IRQ_B[1]));
   COV_ERR: cover property (PSLVERR);
endmodule : dcpet_top_sva

bind dcpet_top dcpet_top_sva #(.N_TIMERS(N_TIMERS), .CNT_W(CNT_W)) u_sva
(
   .CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PIN_A_I(PIN_A_I), .PIN_A_O(PIN_A_O), .PIN_A_OE(PIN_A_OE), .PIN_B_I(PIN_B_I),
   .CMP_OUT(CMP_OUT), .IRQ_A(IRQ_A), .IRQ_B(IRQ_B)
);

// File: bench/dcpet_top_tb.sv
// self-checking bench for the timer block
`timescale 1ns/1ps

module dcpet_top_tb;
   typedef struct {logic e; logic [31:0] d; logic [31:0] m;} dcpet_note_type;
   logic        CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rdata, v;
   logic        PREADY, PSLVERR, CMP_OUT, c1, c3;
   logic [2:0]  PIN_A_I, PIN_A_O, PIN_A_OE, PIN_B_I, IRQ_A, IRQ_B;
   logic [7:0]  b;
   dcpet_note_type notes[$];
   dcpet_note_type nt;
   int          n_fail = 0, n_compared = 0, seed = 3, ch, k, g;

   always #5 CLK = ~CLK;

   dcpet_top dut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PIN_A_I(PIN_A_I), .PIN_A_O(PIN_A_O), .PIN_A_OE(PIN_A_OE), .PIN_B_I(PIN_B_I),
      .CMP_OUT(CMP_OUT), .IRQ_A(IRQ_A), .IRQ_B(IRQ_B));
   dcpet_pins_model pins (.CLK(CLK), .PIN_A_O(PIN_A_O), .PIN_A_OE(PIN_A_OE), .PIN_A_I(PIN_A_I),
      .PIN_B_I(PIN_B_I), .CMP_OUT(CMP_OUT));

   // ----------------------------------------
   // compare, verdict, bus master
   // ----------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      notes.push_back('{e, d, w ? 32'h0 : m});
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 20);
      if (n >= 20)
      begin
         n_fail++;
         print_verdict();
      end
      rdata = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask : rd

   // cycles until pin a output of a channel changes
   task automatic gap(input int c, output int n);
      logic l;
      l = PIN_A_O[c];
      n = 0;
      do @(posedge CLK); while (PIN_A_O[c] === l && ++n < 100);
      if (n >= 100)
      begin
         n_fail++;
         print_verdict();
      end
      n++;
   endtask : gap

   // read monitor: oldest note against each completed transfer
   always @(posedge CLK)
      if (PSEL && PENABLE && PREADY)
      begin
         if (notes.size() == 0) check(33'h1, 33'h0);
         else
         begin
            nt = notes.pop_front();
            check({PSLVERR, PRDATA & nt.m}, {nt.e, nt.d & nt.m});
         end
      end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      for (k = 0; k < 12; k++) rd(8'(k * 4), 32'h0, 32'hffffffff);
      rd(8'h30, 32'h0, 32'hffffffff);
      apb(1'b0, 8'h34, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, 8'h34, 32'h5, 32'h0, 1'b1);
      for (ch = 0; ch < 3; ch++)
      begin
         b = 8'(ch * 16);
         v = $random(seed);
         wr(b + 8'h08, v);
         rd(b + 8'h08, {16'h0, v[15:0]}, 32'hffffffff);
         v = $random(seed);
         wr(b + 8'h0c, v);
         rd(b + 8'h0c, {16'h0, v[15:0]}, 32'hffffffff);
         // pwm with toggle: gaps of reload a + 1 then reload b + 1
         wr(b + 8'h08, 32'h3);
         wr(b + 8'h0c, 32'h5);
         wr(b + 8'h04, 32'h2);
         wr(b, 32'hb4);
         gap(ch, g);
         gap(ch, g);
         check(g, 4);
         gap(ch, g);
         check(g, 6);
         check({PIN_A_OE[ch], IRQ_A[ch], IRQ_B[ch]}, 3'b110);
         rd(b, 32'hbe, 32'hff);
         wr(b, 32'ha0);
         @(posedge CLK);
         check(IRQ_A[ch], 1'b0);
         wr(b + 8'h04, 32'h1234);
         rd(b + 8'h04, 32'h1234, 32'hffff);
         wr(b, 32'h90);
         repeat (3) @(posedge CLK);
         check(PIN_A_OE[ch], 1'b0);
         wr(b, 32'h0);
      end
      // event count on pin a, both polarities, on the third channel
      for (k = 0; k < 2; k++)
      begin
         pins.set_pin(0, 2, k[0]);
         repeat (6) @(posedge CLK);
         wr(8'h28, 32'h1);
         wr(8'h24, 32'h1);
         wr(8'h20, {26'h0, k[0], 5'h15});
         pins.pulse(0, 2, ~k[0]);
         repeat (5) @(posedge CLK);
         check(IRQ_A[2], 1'b0);
         pins.pulse(0, 2, ~k[0]);
         repeat (5) @(posedge CLK);
         check(IRQ_A[2], 1'b1);
      end
      check(IRQ_B[2], 1'b0);
      pins.pulse(1, 2, 1'b1);
      repeat (5) @(posedge CLK);
      check(IRQ_B[2], 1'b1);
      // capture, all edge choices; second channel takes b from the comparator
      wr(8'h30, 32'h1);
      for (ch = 0; ch < 2; ch++)
         for (k = 0; k < 4; k++)
         begin
            b = 8'(ch * 16);
            {c3, c1} = k[1:0];
            pins.set_pin(0, ch, c1);
            pins.set_pin(ch + 1, ch, c3);
            repeat (6) @(posedge CLK);
            wr(b + 8'h04, 32'h8000);
            wr(b, {24'h0, c3, 1'b1, c1, 5'h05});
            pins.pulse(0, ch, ~c1);
            pins.pulse(ch + 1, ch, ~c3);
            repeat (6) @(posedge CLK);
            rd(b + 8'h08, 32'h0, 32'h0);
            v = rdata;
            rd(b + 8'h0c, 32'h0, 32'h0);
            check(v - rdata, 32'h4);
            check({IRQ_A[ch], IRQ_B[ch]}, 2'b11);
         end
      // capture underflow: flag set with enable off, then gated in
      wr(8'h00, 32'h40);
      wr(8'h04, 32'h3);
      repeat (8) @(posedge CLK);
      rd(8'h00, 32'h50, 32'hff);
      check(IRQ_A[0], 1'b0);
      wr(8'h00, 32'h54);
      repeat (2) @(posedge CLK);
      check(IRQ_A[0], 1'b1);
      repeat (4) @(posedge CLK);
      print_verdict();
   end
endmodule : dcpet_top_tb
